//--- verilog/iof_pkg.sv
package iof_pkg;

	// ================================================================
	// Sizes
	localparam int unsigned TBL_WORDS     = 42;
	localparam int unsigned BITS_PER_WORD = 16;
	localparam int unsigned WADDR_W       = 8;
	localparam int unsigned IRQ_W         = 3;

	// ================================================================
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_CMD      = 8'h04;
	localparam logic [7:0] OFF_STATUS   = 8'h08;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h10;

	// ================================================================
	// Field positions
	localparam int unsigned CTRL_EN_BIT   = 0;
	localparam int unsigned CTRL_RUN_BIT  = 1;
	localparam int unsigned CMD_OP_LSB    = 0;
	localparam int unsigned CMD_KIND_LSB  = 4;
	localparam int unsigned CMD_BIT_LSB   = 8;
	localparam int unsigned CMD_ADDR_LSB  = 16;
	localparam int unsigned ST_EN_BIT     = 0;
	localparam int unsigned ST_ACT_BIT    = 1;
	localparam int unsigned ST_USED_LSB   = 8;
	localparam int unsigned IRQ_CMD_ERR   = 0;
	localparam int unsigned IRQ_SCAN_DONE = 1;
	localparam int unsigned IRQ_ACT_RISE  = 2;

	// ================================================================
	// Reset values
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
	localparam logic             RUN_RST      = 1'b1;

	// ================================================================
	// Timing
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned BLINK_HALF_MS = 250;

	// ================================================================
	// Table kinds; the low bit marks an output table
	typedef enum logic [3:0] {
		KIND_DISC_IN   = 4'h0,
		KIND_DISC_OUT  = 4'h1,
		KIND_GDISC_IN  = 4'h2,
		KIND_GDISC_OUT = 4'h3,
		KIND_ANA_IN    = 4'h4,
		KIND_ANA_OUT   = 4'h5,
		KIND_GANA_IN   = 4'h6,
		KIND_GANA_OUT  = 4'h7
	} iof_kind_t;
	localparam logic [3:0] KIND_LAST = 4'h7;

	typedef enum logic [1:0] {
		OP_CLEAR_ALL = 2'h0,
		OP_FORCE_ON  = 2'h1,
		OP_FORCE_OFF = 2'h2,
		OP_REMOVE    = 2'h3
	} iof_op_t;

	typedef enum logic [2:0] {
		S_IDLE    = 3'h4,
		S_IN      = 3'h0,
		S_FIN_RD  = 3'h1,
		S_FIN_WR  = 3'h3,
		S_RUN     = 3'h2,
		S_FOUT_RD = 3'h6,
		S_FOUT_WR = 3'h7,
		S_OUT     = 3'h5
	} iof_state_t;

	// One force word: table, word address, forced-bit mask, forced levels
	typedef struct packed {
		logic [3:0]               kind;
		logic [WADDR_W-1:0]       addr;
		logic [BITS_PER_WORD-1:0] mask;
		logic [BITS_PER_WORD-1:0] val;
	} iof_entry_t;

	// Image table access port toward the I/O images
	typedef struct packed {
		logic                     re;
		logic                     we;
		logic [3:0]               kind;
		logic [WADDR_W-1:0]       addr;
		logic [BITS_PER_WORD-1:0] wdata;
	} iof_img_t;

	// Scan phase requests
	typedef struct packed {
		logic in_req;
		logic prog_req;
		logic out_req;
	} iof_scan_t;

endpackage

//--- verilog/iof_force_overlay.sv
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/10ps
// Summary of operation
// - Clearing the force enable stops all overriding but leaves every force word untouched.
// - Setting the force enable again resumes overriding from the retained force words.
// - Force enable and force table sit on the battery-backed reset, untouched by the bus reset.
// - The clear-all command empties the force table and leaves the force enable as it is.
// - Force-on holds a bit at 1, force-off holds it at 0, remove returns it to the program.
// - Only the discrete, global discrete, analog and global analog in/out tables accept forces.
// - Each scan samples inputs, forces inputs, runs the program, forces outputs, drives outputs.
// - While the program runs the overlay leaves the output image alone, so program writes stand.
// - After the program finishes each forced output bit is rewritten before outputs are driven.
// - The force-enabled flag follows the force enable whether or not any word is in use.
// - The forces-active flag is set only with forcing enabled and at least one bit forced.
// - While forces are active the health indicator blinks.
// - One force word covers 16 consecutive bits, with 42 words shared by inputs and outputs.
module iof_force_overlay #(
	parameter int unsigned TBL_WORDS     = iof_pkg::TBL_WORDS,
	parameter int unsigned BLINK_HALF_MS = iof_pkg::BLINK_HALF_MS,
	parameter int unsigned BLINK_CYC     = BLINK_HALF_MS * 1000000 / iof_pkg::CLK_PERIOD_NS
) (
	input  wire logic                                pclk,
	input  wire logic                                presetn,
	input  wire logic                                bat_rstn,
	input  wire logic                                psel,
	input  wire logic                                penable,
	input  wire logic                                pwrite,
	input  wire logic [7:0]                          paddr,
	input  wire logic [31:0]                         pwdata,
	output logic      [31:0]                         prdata,
	output logic                                     pready,
	output logic                                     pslverr,
	output iof_pkg::iof_img_t                        img,
	input  wire logic [iof_pkg::BITS_PER_WORD-1:0]   img_rdata,
	output iof_pkg::iof_scan_t                       scan,
	input  wire logic                                in_done,
	input  wire logic                                prog_done,
	input  wire logic                                out_done,
	output logic                                     force_enabled_flag,
	output logic                                     forces_active_flag,
	output logic                                     health_indicator,
	output logic                                     irq
);

	// Derived sizes; the index is sized to also hold TBL_WORDS so the walk end fits
	localparam int unsigned IDX_W = $clog2(TBL_WORDS + 1);
	localparam int unsigned BLK_W = $clog2(BLINK_CYC + 1);
	localparam int unsigned BW    = iof_pkg::BITS_PER_WORD;
	localparam logic [IDX_W-1:0] IDX_END   = IDX_W'(TBL_WORDS);
	localparam logic [BLK_W-1:0] BLK_LAST  = BLK_W'(BLINK_CYC - 1);
	localparam logic             RUN_RST_L = iof_pkg::RUN_RST;

	// ================================================================
	// State
	// Every bus-reset flop lives in one struct; retained state sits apart
	typedef struct packed {
		iof_pkg::iof_state_t           st;
		logic [IDX_W-1:0]              idx;
		iof_pkg::iof_img_t             img;
		iof_pkg::iof_scan_t            scan;
		logic                          pready;
		logic [31:0]                   prdata;
		logic                          pslverr;
		logic [iof_pkg::IRQ_W-1:0]     irq_stat;
		logic [iof_pkg::IRQ_W-1:0]     irq_mask;
		logic                          irq;
		logic                          run;
		logic                          en_flag;
		logic                          act_flag;
		logic [BLK_W-1:0]              blk_cnt;
		logic                          blink;
		logic                          health;
	} iof_st_t;

	iof_st_t              s_r;
	iof_st_t              s_nxt;
	logic                 en_r;
	logic                 en_nxt;
	iof_pkg::iof_entry_t  tbl_r   [TBL_WORDS];
	iof_pkg::iof_entry_t  tbl_nxt [TBL_WORDS];

	// ================================================================
	// Bus decode, table search and next state
	always_comb begin
		logic                      wr_acc;
		logic                      rd_acc;
		logic                      setup;
		logic                      mapped;
		logic                      hit;
		logic                      free_ok;
		logic                      any_forced;
		logic [IDX_W-1:0]          hidx;
		logic [IDX_W-1:0]          fidx;
		logic [IDX_W-1:0]          used;
		logic [1:0]                op;
		logic [3:0]                kind;
		logic [3:0]                bsel;
		logic [iof_pkg::WADDR_W-1:0] waddr;
		logic [BW-1:0]             bmask;
		logic [iof_pkg::IRQ_W-1:0] ev;
		logic [31:0]               rd;
		iof_pkg::iof_entry_t       e;
		s_nxt      = s_r;
		en_nxt     = en_r;
		tbl_nxt    = tbl_r;
		ev         = '0;
		hit        = 1'b0;
		free_ok    = 1'b0;
		any_forced = 1'b0;
		hidx       = '0;
		fidx       = '0;
		used       = '0;
		rd         = '0;
		e          = '0;
		setup  = psel & ~penable;
		wr_acc = psel & penable & s_r.pready & pwrite;
		rd_acc = psel & penable & s_r.pready & ~pwrite;
		mapped = (paddr == iof_pkg::OFF_CTRL) || (paddr == iof_pkg::OFF_CMD) ||
			(paddr == iof_pkg::OFF_STATUS) || (paddr == iof_pkg::OFF_IRQ_STAT) ||
			(paddr == iof_pkg::OFF_IRQ_MASK);
		// Command fields sliced always; used only on a command write
		op    = pwdata[iof_pkg::CMD_OP_LSB +: 2];
		kind  = pwdata[iof_pkg::CMD_KIND_LSB +: 4];
		bsel  = pwdata[iof_pkg::CMD_BIT_LSB +: 4];
		waddr = pwdata[iof_pkg::CMD_ADDR_LSB +: iof_pkg::WADDR_W];
		bmask = BW'(1) << bsel;

		// Word in use means any mask bit set; no separate valid bit to drift
		for (int i = 0; i < TBL_WORDS; i++) begin
			if (tbl_r[i].mask != '0) begin
				used       = used + IDX_W'(1);
				any_forced = 1'b1;
				if (!hit && tbl_r[i].kind == kind && tbl_r[i].addr == waddr) begin
					hit  = 1'b1;
					hidx = IDX_W'(i);
				end
			end else if (!free_ok) begin
				free_ok = 1'b1;
				fidx    = IDX_W'(i);
			end
		end

		// Force commands; the enable is never touched here
		// A new word starts from zero, so levels of a freed word never return
		if (wr_acc && paddr == iof_pkg::OFF_CMD) begin
			if (op == iof_pkg::OP_CLEAR_ALL) begin
				for (int i = 0; i < TBL_WORDS; i++) begin
					tbl_nxt[i].mask = '0;
				end
			end else if (kind > iof_pkg::KIND_LAST) begin
				ev[iof_pkg::IRQ_CMD_ERR] = 1'b1;
			end else if (op == iof_pkg::OP_REMOVE) begin
				if (hit) begin
					tbl_nxt[hidx].mask = tbl_r[hidx].mask & ~bmask;
				end
			end else if (hit || free_ok) begin
				e = hit ? tbl_r[hidx] : '0;
				e.kind = kind;
				e.addr = waddr;
				e.mask = e.mask | bmask;
				e.val  = (op == iof_pkg::OP_FORCE_ON) ? (e.val | bmask) : (e.val & ~bmask);
				tbl_nxt[hit ? hidx : fidx] = e;
			end else begin
				ev[iof_pkg::IRQ_CMD_ERR] = 1'b1;
			end
		end

		// Control and mask writes; the enable only gates, the table is kept
		if (wr_acc && paddr == iof_pkg::OFF_CTRL) begin
			en_nxt    = pwdata[iof_pkg::CTRL_EN_BIT];
			s_nxt.run = pwdata[iof_pkg::CTRL_RUN_BIT];
		end
		if (wr_acc && paddr == iof_pkg::OFF_IRQ_MASK) begin
			s_nxt.irq_mask = pwdata[iof_pkg::IRQ_W-1:0];
		end

		// APB answer: no wait state, data loaded in the setup cycle
		// Unmapped addresses answer with an error and read as zero
		s_nxt.pready = setup;
		if (setup) begin
			rd = '0;
			unique case (paddr)
				iof_pkg::OFF_CTRL: begin
					rd[iof_pkg::CTRL_EN_BIT]  = en_r;
					rd[iof_pkg::CTRL_RUN_BIT] = s_r.run;
				end
				iof_pkg::OFF_STATUS: begin
					rd[iof_pkg::ST_EN_BIT]  = s_r.en_flag;
					rd[iof_pkg::ST_ACT_BIT] = s_r.act_flag;
					rd[iof_pkg::ST_USED_LSB +: IDX_W] = used;
				end
				iof_pkg::OFF_IRQ_STAT: rd[iof_pkg::IRQ_W-1:0] = s_r.irq_stat;
				iof_pkg::OFF_IRQ_MASK: rd[iof_pkg::IRQ_W-1:0] = s_r.irq_mask;
				default: rd = '0;
			endcase
			s_nxt.prdata = rd;
		end
		// Error stands with pready only, like the answer itself
		s_nxt.pslverr = setup & ~mapped;

		// Status flags
		// Flags lag the enable by one cycle, like every registered output
		s_nxt.en_flag  = en_r;
		s_nxt.act_flag = en_r & any_forced;
		if (s_nxt.act_flag && !s_r.act_flag) begin
			ev[iof_pkg::IRQ_ACT_RISE] = 1'b1;
		end

		// Scan loop; requests are one-cycle pulses
		// Index one past the last word marks the end of a walk
		s_nxt.scan     = '0;
		s_nxt.img.re   = 1'b0;
		s_nxt.img.we   = 1'b0;
		e = tbl_r[s_r.idx < IDX_END ? s_r.idx : '0];
		unique case (s_r.st)
			iof_pkg::S_IDLE: begin
				if (s_r.run) begin
					s_nxt.scan.in_req = 1'b1;
					s_nxt.st          = iof_pkg::S_IN;
				end
			end
			iof_pkg::S_IN: begin
				if (in_done) begin
					s_nxt.idx = '0;
					s_nxt.st  = iof_pkg::S_FIN_RD;
				end
			end
			iof_pkg::S_FIN_RD, iof_pkg::S_FOUT_RD: begin
				if (s_r.idx == IDX_END) begin
					s_nxt.idx = '0;
					if (s_r.st == iof_pkg::S_FIN_RD) begin
						s_nxt.scan.prog_req = 1'b1;
						s_nxt.st            = iof_pkg::S_RUN;
					end else begin
						s_nxt.scan.out_req = 1'b1;
						s_nxt.st           = iof_pkg::S_OUT;
					end
				end else if (en_r && e.mask != '0 &&
					e.kind[0] == (s_r.st == iof_pkg::S_FOUT_RD)) begin
					s_nxt.img.re   = 1'b1;
					s_nxt.img.kind = e.kind;
					s_nxt.img.addr = e.addr;
					s_nxt.st = (s_r.st == iof_pkg::S_FIN_RD) ?
						iof_pkg::S_FIN_WR : iof_pkg::S_FOUT_WR;
				end else begin
					s_nxt.idx = s_r.idx + IDX_W'(1);
				end
			end
			iof_pkg::S_FIN_WR, iof_pkg::S_FOUT_WR: begin
				// Live entry used: a command landing mid-walk applies at once
				// Enable dropped since the read: write the word back untouched
				if (!en_r) begin
					e.mask = '0;
				end
				s_nxt.img.we    = 1'b1;
				s_nxt.img.wdata = (img_rdata & ~e.mask) | (e.val & e.mask);
				s_nxt.idx       = s_r.idx + IDX_W'(1);
				s_nxt.st = (s_r.st == iof_pkg::S_FIN_WR) ?
					iof_pkg::S_FIN_RD : iof_pkg::S_FOUT_RD;
			end
			iof_pkg::S_RUN: begin
				// Image left to the program until it reports done
				// Program writes to forced outputs stand until the output walk
				if (prog_done) begin
					s_nxt.st = iof_pkg::S_FOUT_RD;
				end
			end
			iof_pkg::S_OUT: begin
				if (out_done) begin
					ev[iof_pkg::IRQ_SCAN_DONE] = 1'b1;
					s_nxt.st = iof_pkg::S_IDLE;
				end
			end
		endcase

		// Health indicator: steady on, blinking while forces are active
		// Limitation: the blink phase restarts whenever forcing turns on
		if (s_r.act_flag) begin
			if (s_r.blk_cnt == BLK_LAST) begin
				s_nxt.blk_cnt = '0;
				s_nxt.blink   = ~s_r.blink;
			end else begin
				s_nxt.blk_cnt = s_r.blk_cnt + BLK_W'(1);
			end
			s_nxt.health = s_r.blink;
		end else begin
			s_nxt.blk_cnt = '0;
			s_nxt.blink   = 1'b1;
			s_nxt.health  = 1'b1;
		end

		// Sticky events; a new event wins over the read that clears
		// Hence a clear never loses an event raised in that same cycle
		if (rd_acc && paddr == iof_pkg::OFF_IRQ_STAT) begin
			s_nxt.irq_stat = ev;
		end else begin
			s_nxt.irq_stat = s_r.irq_stat | ev;
		end
		s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
	end

	// ================================================================
	// Bus-reset state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r          <= '0;
			s_r.st       <= iof_pkg::S_IDLE;
			s_r.irq_mask <= iof_pkg::IRQ_MASK_RST;
			s_r.run      <= RUN_RST_L;
			s_r.blink    <= 1'b1;
			s_r.health   <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ================================================================
	// Retained state: cleared only by the battery power-on reset
	// Kept apart so a bus reset cannot disturb forces in effect
	always_ff @(posedge pclk or negedge bat_rstn) begin
		if (!bat_rstn) begin
			en_r <= 1'b0;
			for (int i = 0; i < TBL_WORDS; i++) begin
				tbl_r[i] <= '0;
			end
		end else begin
			en_r  <= en_nxt;
			tbl_r <= tbl_nxt;
		end
	end

	// ================================================================
	// Outputs, all from flops
	assign prdata             = s_r.prdata;
	assign pready             = s_r.pready;
	assign pslverr            = s_r.pslverr;
	assign img                = s_r.img;
	assign scan               = s_r.scan;
	assign force_enabled_flag = s_r.en_flag;
	assign forces_active_flag = s_r.act_flag;
	assign health_indicator   = s_r.health;
	assign irq                = s_r.irq;

endmodule

//--- sim/iof_io_model.sv
`timescale 1ns/10ps
// ==========
// Far side: image words, I/O points and a stand-in user program
module iof_io_model (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire iof_pkg::iof_img_t  img,
	input  wire iof_pkg::iof_scan_t scan,
	input  wire logic [15:0]        pin,
	input  wire logic [15:0]        pv,
	input  wire logic [1:0]         lat,
	output logic      [15:0]        img_rdata,
	output logic                    in_done,
	output logic                    prog_done,
	output logic                    out_done,
	output logic      [15:0]        saw,
	output logic      [15:0]        pout
);
	logic [15:0] mem [0:2047];
	logic [10:0] ix;
	logic [1:0]  cnt;
	logic [2:0]  which;

	// Blank image at power up
	initial for (int i = 0; i < 2048; i++) mem[i] = 16'h0000;

	// Combinational read; garbage outside a read so stale data never matches
	assign ix = {img.kind[2:0], img.addr};
	assign img_rdata = img.re ? mem[ix] : ~mem[ix];

	// Sample point, program run, output latch, overlay writes
	always @(posedge pclk) begin
		if (scan.in_req)
			mem[0] <= pin;
		if (scan.prog_req) begin
			saw <= mem[0];
			mem[256] <= pv;
		end
		if (scan.out_req)
			pout <= mem[256];
		if (img.we)
			mem[ix] <= img.wdata;
	end

	// Each phase answered after lat cycles with a one-cycle done
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 2'h0;
			which <= 3'h0;
		end else if (scan.in_req | scan.prog_req | scan.out_req) begin
			cnt <= lat;
			which <= {scan.in_req, scan.prog_req, scan.out_req};
		end else if (cnt != 2'h0)
			cnt <= cnt - 2'h1;
	end
	assign {in_done, prog_done, out_done} = (cnt == 2'h1) ? which : 3'h0;
endmodule

//--- sim/iof_force_overlay_asserts.sv
`timescale 1ns/10ps
// ==========
// Port checks for the force overlay
module iof_chk #(
	parameter int unsigned BLINK_CYC = 4
) (
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pready,
	input wire logic               pslverr,
	input wire iof_pkg::iof_img_t  img,
	input wire iof_pkg::iof_scan_t scan,
	input wire logic               prog_done,
	input wire logic               force_enabled_flag,
	input wire logic               forces_active_flag,
	input wire logic               health_indicator
);
	logic [1:0]  ph_r;
	logic        pw_r;
	logic [31:0] hc_r;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Last scan phase, program window, steady-health run length
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ph_r <= 2'h0;
			pw_r <= 1'b0;
			hc_r <= 32'h0;
		end else begin
			if (scan.in_req)
				ph_r <= 2'h1;
			else if (scan.prog_req)
				ph_r <= 2'h2;
			else if (scan.out_req)
				ph_r <= 2'h3;
			pw_r <= scan.prog_req | (pw_r & ~prog_done);
			hc_r <= (forces_active_flag && $stable(health_indicator)) ? hc_r + 32'h1 : 32'h0;
		end
	end

	property p_rdy; psel && !penable |=> pready ##1 !pready; endproperty
	property p_err; pslverr |-> pready; endproperty
	property p_in; scan.in_req |-> ph_r == 2'h0 || ph_r == 2'h3; endproperty
	property p_prog; scan.prog_req |-> ph_r == 2'h1; endproperty
	property p_out; scan.out_req |-> ph_r == 2'h2; endproperty
	property p_quiet; pw_r |-> !img.re && !img.we; endproperty
	property p_dir; img.re |-> img.kind[0] == (ph_r == 2'h2); endproperty
	property p_kind; img.re |-> img.kind <= 4'h7; endproperty
	property p_rmw; img.re |=> img.we && $stable(img.kind) && $stable(img.addr); endproperty
	property p_act; forces_active_flag |-> force_enabled_flag; endproperty
	property p_steady; !forces_active_flag [*3] |-> health_indicator; endproperty
	property p_blink; hc_r <= BLINK_CYC + 2; endproperty

	a_rdy: assert property (p_rdy) else $error("ready not single");
	a_err: assert property (p_err) else $error("error without ready");
	a_in: assert property (p_in) else $error("sample out of order");
	a_prog: assert property (p_prog) else $error("program out of order");
	a_out: assert property (p_out) else $error("drive out of order");
	a_quiet: assert property (p_quiet) else $error("image touched in program");
	a_dir: assert property (p_dir) else $error("walk on wrong table");
	a_kind: assert property (p_kind) else $error("bad table kind");
	a_rmw: assert property (p_rmw) else $error("read not followed by write");
	a_act: assert property (p_act) else $error("active while disabled");
	a_steady: assert property (p_steady) else $error("indicator not steady");
	a_blink: assert property (p_blink) else $error("indicator not blinking");

	c_rmw: cover property (img.re ##1 img.we);
	c_err: cover property (pslverr);
	c_act: cover property ($rose(forces_active_flag));
endmodule

bind iof_force_overlay iof_chk #(.BLINK_CYC(BLINK_CYC)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .img(img), .scan(scan),
	.prog_done(prog_done), .force_enabled_flag(force_enabled_flag),
	.forces_active_flag(forces_active_flag), .health_indicator(health_indicator)
);

//--- sim/iof_force_overlay_tb_top.sv
`timescale 1ns/10ps
// ==========
// Bench for the force overlay
module iof_force_overlay_tb_top;
	logic               pclk = 1'b0, presetn = 1'b0, bat_rstn = 1'b0;
	logic               psel = 1'b0, penable = 1'b0, pwrite = 1'b0, en = 1'b0;
	logic [7:0]         paddr = 8'h00;
	logic [31:0]        pwdata = 32'h0, prdata, rv;
	logic               pready, pslverr, serr, in_done, prog_done, out_done;
	logic               fen, fact, health, irq;
	logic [15:0]        img_rdata, saw, pout, pin = 16'h0, pv = 16'h0;
	logic [1:0]         lat = 2'h1;
	iof_pkg::iof_img_t  img;
	iof_pkg::iof_scan_t scan;
	int                 err_total = 0, checks = 0, ist = 0, cyc = 0;
	int                 em[int], ev[int];

	// 50 MHz bus clock
	always #10 pclk = ~pclk;

	// Short blink period keeps the run brief
	iof_force_overlay #(.BLINK_CYC(4)) uut (
		.pclk(pclk), .presetn(presetn), .bat_rstn(bat_rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .img(img),
		.img_rdata(img_rdata), .scan(scan), .in_done(in_done), .prog_done(prog_done),
		.out_done(out_done), .force_enabled_flag(fen), .forces_active_flag(fact),
		.health_indicator(health), .irq(irq));
	iof_io_model io (
		.pclk(pclk), .presetn(presetn), .img(img), .scan(scan), .pin(pin), .pv(pv),
		.lat(lat), .img_rdata(img_rdata), .in_done(in_done), .prog_done(prog_done),
		.out_done(out_done), .saw(saw), .pout(pout));

	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// One bus transfer, then an idle cycle
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rv = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		cmp(rv & m, e);
	endtask

	task automatic st_chk();
		int n;
		logic [31:0] e;
		n = em.num();
		e = {18'h0, n[5:0], 6'h0, en && n > 0, en};
		rd(iof_pkg::OFF_STATUS, 32'hFFFFFFFF, e);
		cmp({fact, fen}, e[1:0]);
	endtask

	// Command plus its effect on the reference table
	task automatic fc(input int op, input int k, input int b, input int a);
		int key = k * 256 + a;
		if (op == 0) begin
			em.delete();
			ev.delete();
		end else if (k > 7 || (op != 3 && !em.exists(key) && em.num() == 42)) begin
			ist = 1;
		end else if (op != 3) begin
			if (!em.exists(key)) begin
				em[key] = 0;
				ev[key] = 0;
			end
			em[key] |= 1 << b;
			ev[key] = (op == 1) ? ev[key] | (1 << b) : ev[key] & ~(1 << b);
		end else if (em.exists(key) && (em[key] & ~(1 << b)) == 0) begin
			em.delete(key);
			ev.delete(key);
		end else if (em.exists(key)) begin
			em[key] &= ~(1 << b);
		end
		apb(1'b1, iof_pkg::OFF_CMD, {8'h00, 8'(a), 4'h0, 4'(b), 4'(k), 2'h0, 2'(op)});
	endtask

	task automatic irq_chk();
		repeat (3) @(posedge pclk);
		cmp(irq, ist != 0);
		rd(iof_pkg::OFF_IRQ_STAT, 32'h1, 32'(ist));
		ist = 0;
		repeat (3) @(posedge pclk);
		cmp(irq, 1'b0);
	endtask

	function automatic int ov(int x, int key);
		if (!en || !em.exists(key))
			return x;
		return (x & ~em[key]) | (ev[key] & em[key]);
	endfunction

	// One full scan with fresh inputs and program value
	task automatic scan_chk(input string s);
		int tg = 0;
		logic h;
		pin <= 16'($urandom);
		pv <= 16'($urandom);
		lat <= 2'($urandom_range(1, 3));
		@(posedge pclk iff scan.in_req);
		h = health;
		while (scan.out_req !== 1'b1) begin
			@(posedge pclk);
			tg += int'(health !== h);
			h = health;
		end
		@(posedge pclk);
		cmp(saw, ov(pin, 0));
		cmp(pout, ov(pv, 256));
		cmp(tg > 0, en && em.num() > 0);
		$display("test %s done", s);
	endtask

	task automatic end_sim();
		$display("checks=%0d mismatches=%0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Hang guard
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			end_sim();
		end
	end

	initial begin
		void'($urandom(32'hEEC9));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		bat_rstn <= 1'b1;
		@(posedge pclk);
		rd(iof_pkg::OFF_CTRL, 32'h3, 32'h2);
		rd(iof_pkg::OFF_IRQ_MASK, 32'h7, 32'h0);
		st_chk();
		rd(8'h14, 32'hFFFFFFFF, 32'h0);
		cmp(serr, 1'b1);
		apb(1'b1, iof_pkg::OFF_IRQ_MASK, 32'h1);
		apb(1'b1, iof_pkg::OFF_CTRL, 32'h3);
		en = 1'b1;
		for (int k = 0; k < 8; k++) fc(1, k, k, 0);
		fc(2, 1, 5, 0);
		fc(2, 0, 9, 0);
		irq_chk();
		st_chk();
		repeat (3) scan_chk("force");
		apb(1'b1, iof_pkg::OFF_CTRL, 32'h2);
		en = 1'b0;
		st_chk();
		scan_chk("disable");
		apb(1'b1, iof_pkg::OFF_CTRL, 32'h3);
		en = 1'b1;
		scan_chk("enable");
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b1, iof_pkg::OFF_IRQ_MASK, 32'h1);
		st_chk();
		scan_chk("bus reset");
		fc(3, 0, 0, 0);
		fc(3, 1, 1, 0);
		fc(3, 1, 4, 0);
		fc(3, 7, 7, 0);
		st_chk();
		scan_chk("remove");
		fc(1, 8, 0, 0);
		irq_chk();
		fc(0, 0, 0, 0);
		st_chk();
		scan_chk("clear");
		for (int i = 0; i < 43; i++) fc(1, 0, i % 16, i);
		st_chk();
		irq_chk();
		scan_chk("full");
		end_sim();
	end
endmodule
